/* File: dv/flash_erase_assertions.sv */
// Purpose: Temporal checks on the serial erase link.
// Assumes: Both link ends are design modules.
// Notes: Bounds are in mclk cycles.
`timescale 1ns/1ps
module flash_erase_assertions (
  input wire logic mclk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire logic sclk, // Serial clock.
  input wire logic cs_n, // Select.
  input wire logic reset_n, // Reset pin.
  input wire logic busy_flag, // Cycle running.
  input wire logic write_permit_latch // Permit latch.
);
  logic [15:0] bcnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // --------------------
  // Checks
  // --------------------
  // Busy length; the shortest walk is 256 bytes, so less is a bug.
  always_ff @(posedge mclk) begin
    if (sys_rst || !busy_flag) begin
      bcnt <= 16'h0000;
    end else if (bcnt != 16'hffff) begin
      bcnt <= bcnt + 16'h0001;
    end
  end
  AST_PWRUP: assert property ($fell(sys_rst) |->
    !busy_flag && !write_permit_latch) else $error("bad reset state");
  AST_START: assert property ($rose(busy_flag) |->
    write_permit_latch && cs_n) else $error("start without latch");
  AST_FRAME: assert property ($rose(busy_flag) |->
    !$past(cs_n, 8)) else $error("start not after frame");
  AST_DONE: assert property ($fell(busy_flag) |->
    !write_permit_latch) else $error("latch kept at end");
  AST_PIN: assert property ($fell(reset_n) |-> ##[1:5]
    (!busy_flag && !write_permit_latch)) else $error("pin reset lost");
  AST_NOARM: assert property (busy_flag && $past(busy_flag) |->
    !$rose(write_permit_latch)) else $error("latch set in cycle");
  AST_HOLD: assert property ($fell(cs_n) |-> !cs_n [*8])
    else $error("select released early");
  AST_IDLE: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("clock moves while idle");
  AST_WAIT: assert property ($rose(reset_n) |-> cs_n [*8])
    else $error("select too soon after reset");
  AST_LEN: assert property ($fell(busy_flag) && reset_n |->
    bcnt >= 16'h00ff) else $error("cycle too short");
endmodule : flash_erase_assertions

/* File: dv/test_serial_flash_erase_commands.sv */
// Purpose: Drives erase commands end to end through the controller.
// Assumes: Full erase never finishes here; it is only aborted.
// Notes: Mid-block completion is skipped to keep the run short.
`timescale 1ns/1ps
module test_serial_flash_erase_commands;
  import flash_erase_pkg::*;
  logic mclk, sys_rst, mem_wr_en, busy_flag, write_permit_latch;
  logic [7:0] hw_prot, sw_lock, mem_wr_data, mem_rd_data, flags;
  logic [18:0] mem_addr;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, v;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int mismatches, compares;
  // Device flags as a status byte: bit 1 latch, bit 0 busy.
  assign flags = {6'h0, write_permit_latch, busy_flag};
  flash_link_if lnk();
  flash_erase_dev #(.PAGE_CLEAR_CYC(300), .SMALL_CLEAR_CYC(5000),
    .MID_CLEAR_CYC(70000), .FULL_CLEAR_CYC(600000)) flash_erase_dev_i (
    .mclk(mclk), .sys_rst(sys_rst), .lnk(lnk), .hw_prot(hw_prot),
    .sw_lock(sw_lock), .mem_wr_en(mem_wr_en), .mem_addr(mem_addr),
    .mem_wr_data(mem_wr_data), .mem_rd_data(mem_rd_data),
    .busy_flag(busy_flag), .write_permit_latch(write_permit_latch));
  flash_erase_host #(.SCLK_HALF(6)) flash_erase_host_i (.mclk(mclk),
    .sys_rst(sys_rst), .lnk(lnk), .s_awaddr(awaddr), .s_awvalid(awvalid),
    .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
    .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr),
    .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
    .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready));
  flash_erase_assertions flash_erase_assertions_i (.mclk(mclk),
    .sys_rst(sys_rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .reset_n(lnk.reset_n), .busy_flag(busy_flag),
    .write_permit_latch(write_permit_latch));
  // --------------------
  // Tasks
  // --------------------
  task automatic end_of_test();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %0t saw %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n >= 9000) begin
      mismatches++;
      $display("[FAIL] %0t wait ran out", $time);
      end_of_test();
    end
  endtask : tmo
  // Each channel is released at the edge that takes it.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 9000);
    bready <= 1'b0;
    tmo(n);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 9000);
    v = rdata;
    rready <= 1'b0;
    tmo(n);
  endtask : rd
  // Frame helper: waits for the engine so commands are never dropped.
  task automatic idle();
    int n;
    n = 0;
    do begin
      rd(REG_STATUS);
      n++;
    end while (v[0] !== 1'b0 && n < 9000);
    tmo(n);
  endtask : idle
  task automatic frame(input logic [7:0] op, input logic [3:0] nb,
                       input logic [23:0] a);
    idle();
    wr(REG_ADDR, {8'h00, a});
    wr(REG_CMD, {19'h0, nb[3], 1'b0, nb[2:0], op});
    idle();
    repeat (8) @(posedge mclk);
  endtask : frame
  task automatic status(input logic [7:0] e);
    frame(OP_STATUS_READ, 4'h9, 24'h000000);
    chk(v[15:8] & 8'h03, e);
  endtask : status
  task automatic poke(input logic [18:0] a, input logic [7:0] d);
    @(posedge mclk);
    mem_addr <= a;
    mem_wr_data <= d;
    mem_wr_en <= 1'b1;
    @(posedge mclk);
    mem_wr_en <= 1'b0;
  endtask : poke
  task automatic peek(input logic [18:0] a, input logic [7:0] e);
    @(posedge mclk);
    mem_addr <= a;
    repeat (2) @(posedge mclk);
    chk(mem_rd_data, e);
  endtask : peek
  task automatic wbusy(input logic b);
    int n;
    n = 0;
    while (busy_flag !== b && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    tmo(n);
  endtask : wbusy
  // --------------------
  // Clock and sequence
  // --------------------
  // Free-running 250 MHz system clock.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Main sequence; status bits 0 and 1 are busy and latch.
  initial begin
    {sys_rst, hw_prot, sw_lock, mem_wr_en, mem_wr_data} = 26'h2000000;
    {mem_addr, awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, mismatches, compares} = '0;
    wstrb = 4'hf;
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk(flags, 8'h00);
    poke(19'h00100, 8'h5a);
    poke(19'h001ff, 8'h00);
    poke(19'h00200, 8'h33);
    poke(19'h00300, 8'h11);
    poke(19'h01abc, 8'h22);
    poke(19'h02000, 8'h44);
    frame(OP_PAGE_CLEAR, 4'h4, 24'h000100);
    peek(19'h00100, 8'h5a);
    frame(OP_WRITE_PERMIT, 4'h1, 24'h0);
    status(8'h02);
    frame(OP_PAGE_CLEAR, 4'h1, 24'h000100);
    chk(flags, 8'h02);
    frame(OP_PAGE_CLEAR, 4'h4, 24'hf80123);
    wbusy(1'b0);
    chk(flags, 8'h00);
    peek(19'h00100, ERASED_BYTE);
    peek(19'h001ff, ERASED_BYTE);
    peek(19'h00200, 8'h33);
    hw_prot <= 8'h01;
    frame(OP_WRITE_PERMIT, 4'h1, 24'h0);
    frame(OP_PAGE_CLEAR, 4'h4, 24'h000300);
    peek(19'h00300, 8'h11);
    chk(flags, 8'h02);
    hw_prot <= 8'h00;
    sw_lock <= 8'h01;
    frame(OP_SMALL_CLEAR, 4'h4, 24'h001000);
    chk(flags, 8'h02);
    sw_lock <= 8'h00;
    frame(OP_SMALL_CLEAR, 4'h4, 24'h001000);
    status(8'h03);
    frame(OP_PAGE_CLEAR, 4'h4, 24'h002000);
    wbusy(1'b0);
    peek(19'h01abc, ERASED_BYTE);
    peek(19'h02000, 8'h44);
    hw_prot <= 8'h02;
    frame(OP_WRITE_PERMIT, 4'h1, 24'h0);
    frame(OP_MID_CLEAR, 4'h4, 24'h010000);
    chk(flags, 8'h02);
    hw_prot <= 8'h00;
    frame(OP_MID_CLEAR, 4'h4, 24'h01ffff);
    chk(flags, 8'h03);
    wr(REG_RESET, 32'h1);
    frame(OP_WRITE_PERMIT, 4'h1, 24'h0);
    sw_lock <= 8'h04;
    frame(OP_FULL_CLEAR, 4'h1, 24'h0);
    chk(flags, 8'h02);
    sw_lock <= 8'h00;
    frame(OP_FULL_CLEAR, 4'h4, 24'h0);
    chk(flags, 8'h02);
    frame(OP_FULL_CLEAR, 4'h1, 24'h0);
    chk(flags, 8'h03);
    wr(REG_RESET, 32'h1);
    repeat (10) @(posedge mclk);
    chk(flags, 8'h00);
    status(8'h00);
    end_of_test();
  end
endmodule : test_serial_flash_erase_commands

/* File: rtl/flash_erase_dev.sv */
// Purpose: Erase instruction handling of a serial flash device.
// Assumes: Link pins are asynchronous to mclk and pass two flops.
// Notes: Memory array is modelled on chip with a user-side port.
// Summary of operation
// - Page erase sets whole page to ones.
// - Erases need latch; permit command sets it.
// - Page erase: opcode plus three address bytes.
// - Address bits 23 to 19 ignored.
// - Select must rise exactly after address byte.
// - Host keeps select low whole command.
// - Select rise starts cycle; busy flag tracks.
// - Status reads answered during erase cycle.
// - Latch cleared by cycle completion.
// - Page erase refused in hardware protected sector.
// - Small-block erase, variant only; subsector ones.
// - Small-block refused if any protection there.
// - Mid-block erase sets whole sector ones.
// - Mid-block refused on hardware protected sector.
// - Full erase sets whole array ones.
// - Full erase is opcode only, exact framing.
// - Full erase refused if anything protected.
// - Erase during running cycle is rejected.
// - Reset pin aborts cycle, resets device.
// - Host waits after reset before selecting.
// - Latch and busy clear at power-up.
`timescale 1ns/1ps
module flash_erase_dev #(
  parameter int MEM_AW = 19, // Array address width, bytes.
  parameter int N_SECT = 8, // Number of 64 Kbyte sectors.
  parameter bit HAS_SMALL_FULL = 1'b1, // Variant decodes small/full.
  parameter int PAGE_CLEAR_CYC = 2048, // Page erase cycle length.
  parameter int SMALL_CLEAR_CYC = 8192, // Small-block cycle length.
  parameter int MID_CLEAR_CYC = 131072, // Mid-block cycle length.
  parameter int FULL_CLEAR_CYC = 600000 // Full-array cycle length.
) (
  input wire logic mclk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  flash_link_if.dev lnk, // Serial link.
  input wire logic [N_SECT-1:0] hw_prot, // Hardware protected sectors.
  input wire logic [N_SECT-1:0] sw_lock, // Software locked sectors.
  input wire logic mem_wr_en, // Preload write strobe.
  input wire logic [MEM_AW-1:0] mem_addr, // Preload/inspect address.
  input wire logic [7:0] mem_wr_data, // Preload data.
  output logic [7:0] mem_rd_data, // Registered array read.
  output logic busy_flag, // Erase cycle running.
  output logic write_permit_latch // Write permit latch.
);
  import flash_erase_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_WALK = 2'b01, ST_HOLD = 2'b11
  } cyc_state_type;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [1:0] sclk_s, csn_s, si_s, rstn_s;
  logic sclk_d, csn_d;

  // Stage 0 feeds only stage 1; edge detect looks at stage 1 onward.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclk_s <= 2'b00;
      csn_s <= 2'b11;
      si_s <= 2'b00;
      rstn_s <= 2'b11;
      sclk_d <= 1'b0;
      csn_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], lnk.sclk};
      csn_s <= {csn_s[0], lnk.cs_n};
      si_s <= {si_s[0], lnk.si};
      rstn_s <= {rstn_s[0], lnk.reset_n};
      sclk_d <= sclk_s[1];
      csn_d <= csn_s[1];
    end
  end

  logic pin_rst, rst_all, cs_low, cs_fall, cs_rise, sclk_rise, sclk_fall;
  assign pin_rst = ~rstn_s[1];
  assign rst_all = sys_rst | pin_rst;
  assign cs_low = ~csn_s[1];
  assign cs_fall = csn_d & ~csn_s[1];
  assign cs_rise = ~csn_d & csn_s[1];
  assign sclk_rise = sclk_s[1] & ~sclk_d & cs_low;
  assign sclk_fall = ~sclk_s[1] & sclk_d & cs_low;

  // ----------------------------------------------------------------------
  // Command shifter
  // ----------------------------------------------------------------------
  logic [31:0] shift_reg;
  logic [5:0] bits_reg;
  logic [7:0] op_reg;

  // Bit count saturates so a long frame never aliases an exact count.
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      shift_reg <= '0;
      bits_reg <= '0;
      op_reg <= '0;
    end else if (cs_fall) begin
      bits_reg <= '0;
      op_reg <= '0;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[30:0], si_s[1]};
      if (bits_reg != BITS_SAT) begin
        bits_reg <= bits_reg + 6'h01;
      end
      if (bits_reg == BITS_OP_ONLY - 6'h01) begin
        op_reg <= {shift_reg[6:0], si_s[1]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Status read-out
  // ----------------------------------------------------------------------
  logic [7:0] status_now, stat_snap;
  logic [2:0] out_cnt;
  logic so_reg, so_oe_reg, stat_mode;
  assign stat_mode = (op_reg == OP_STATUS_READ) &&
                     (bits_reg >= BITS_OP_ONLY);

  always_comb begin
    status_now = 8'h00;
    status_now[STAT_BUSY_BIT] = busy_flag;
    status_now[STAT_LATCH_BIT] = write_permit_latch;
  end

  // Served in every state, so busy can be polled mid-cycle.
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
      out_cnt <= '0;
      stat_snap <= '0;
    end else begin
      so_oe_reg <= cs_low & stat_mode;
      if (cs_fall) begin
        out_cnt <= '0;
      end else if (sclk_fall && stat_mode) begin
        out_cnt <= out_cnt + 3'h1;
        if (out_cnt == 3'h0) begin
          stat_snap <= status_now;
          so_reg <= status_now[7];
        end else begin
          so_reg <= stat_snap[3'h7 - out_cnt];
        end
      end
    end
  end
  assign lnk.so = so_reg;
  assign lnk.so_oe = so_oe_reg;

  // ----------------------------------------------------------------------
  // Command decode at select rise
  // ----------------------------------------------------------------------
  function automatic logic [N_SECT-1:0] sect_bit(
    input logic [MEM_AW-1:0] a);
    logic [N_SECT-1:0] r;
    r = '0;
    r[a[MEM_AW-1:MID_AW]] = 1'b1;
    return r;
  endfunction : sect_bit

  logic [MEM_AW-1:0] cmd_addr, mask;
  logic [N_SECT-1:0] sel;
  logic exact_op, exact_addr, permit_set;
  erase_kind_type start_kind;
  // Only the low address bits take part; upper bits are don't care.
  assign cmd_addr = shift_reg[MEM_AW-1:0];
  assign sel = sect_bit(cmd_addr);
  assign exact_op = (bits_reg == BITS_OP_ONLY);
  assign exact_addr = (bits_reg == BITS_OP_ADDR);

  always_comb begin
    start_kind = KIND_NONE;
    permit_set = 1'b0;
    mask = '0;
    if (cs_rise && !busy_flag) begin
      case (op_reg)
        OP_WRITE_PERMIT: permit_set = exact_op;
        OP_PAGE_CLEAR: begin
          mask = MEM_AW'((1 << PAGE_AW) - 1);
          if (exact_addr && write_permit_latch && !(|(sel & hw_prot)))
            start_kind = KIND_PAGE;
        end
        OP_SMALL_CLEAR: begin
          mask = MEM_AW'((1 << SMALL_AW) - 1);
          if (HAS_SMALL_FULL && exact_addr && write_permit_latch &&
              !(|(sel & (hw_prot | sw_lock))))
            start_kind = KIND_SMALL;
        end
        OP_MID_CLEAR: begin
          mask = MEM_AW'((1 << MID_AW) - 1);
          if (exact_addr && write_permit_latch && !(|(sel & hw_prot)))
            start_kind = KIND_MID;
        end
        OP_FULL_CLEAR: begin
          mask = '1;
          if (HAS_SMALL_FULL && exact_op && write_permit_latch &&
              !(|(hw_prot | sw_lock)))
            start_kind = KIND_FULL;
        end
        default: start_kind = KIND_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Self-timed erase cycle
  // ----------------------------------------------------------------------
  function automatic logic [31:0] cyc_of(input erase_kind_type k);
    case (k)
      KIND_PAGE: return 32'(PAGE_CLEAR_CYC);
      KIND_SMALL: return 32'(SMALL_CLEAR_CYC);
      KIND_MID: return 32'(MID_CLEAR_CYC);
      default: return 32'(FULL_CLEAR_CYC);
    endcase
  endfunction : cyc_of

  cyc_state_type state_reg;
  logic [MEM_AW-1:0] ptr_reg, end_reg;
  logic [31:0] tcnt_reg, tlim_reg;

  // The walk clears one byte per cycle; the hold pads to the set length.
  always_ff @(posedge mclk) begin
    if (rst_all) begin
      state_reg <= ST_IDLE;
      busy_flag <= 1'b0;
      write_permit_latch <= 1'b0;
      ptr_reg <= '0;
      end_reg <= '0;
      tcnt_reg <= '0;
      tlim_reg <= '0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (permit_set) begin
            write_permit_latch <= 1'b1;
          end
          if (start_kind != KIND_NONE) begin
            state_reg <= ST_WALK;
            busy_flag <= 1'b1;
            ptr_reg <= cmd_addr & ~mask;
            end_reg <= cmd_addr | mask;
            tcnt_reg <= 32'h1;
            tlim_reg <= cyc_of(start_kind);
          end
        end
        ST_WALK: begin
          tcnt_reg <= tcnt_reg + 32'h1;
          if (ptr_reg == end_reg) begin
            state_reg <= ST_HOLD;
          end else begin
            ptr_reg <= ptr_reg + MEM_AW'(1);
          end
        end
        ST_HOLD: begin
          tcnt_reg <= tcnt_reg + 32'h1;
          if (tcnt_reg >= tlim_reg) begin
            state_reg <= ST_IDLE;
            busy_flag <= 1'b0;
            write_permit_latch <= 1'b0;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Memory array
  // ----------------------------------------------------------------------
  logic [7:0] mem [2**MEM_AW];

  // User preload is locked out during a cycle so it cannot race the walk.
  always_ff @(posedge mclk) begin
    if (state_reg == ST_WALK) begin
      mem[ptr_reg] <= ERASED_BYTE;
    end else if (mem_wr_en && !busy_flag) begin
      mem[mem_addr] <= mem_wr_data;
    end
    mem_rd_data <= mem[mem_addr];
  end
endmodule : flash_erase_dev

/* File: rtl/flash_erase_host.sv */
// Purpose: Controller end issuing flash instructions from AXI4-Lite.
// Assumes: Device output line is sampled through two flops.
// Notes: SCLK_HALF must stay at six or more for the read return path.
`timescale 1ns/1ps
module flash_erase_host #(
  parameter int SCLK_HALF = 6 // mclk cycles per serial clock half.
) (
  input wire logic mclk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  flash_link_if.host lnk, // Serial link.
  input wire logic [3:0] s_awaddr, // Write address.
  input wire logic s_awvalid, // Write address valid.
  output logic s_awready, // Write address ready.
  input wire logic [31:0] s_wdata, // Write data.
  input wire logic [3:0] s_wstrb, // Write strobes.
  input wire logic s_wvalid, // Write data valid.
  output logic s_wready, // Write data ready.
  output logic [1:0] s_bresp, // Write response.
  output logic s_bvalid, // Write response valid.
  input wire logic s_bready, // Write response ready.
  input wire logic [3:0] s_araddr, // Read address.
  input wire logic s_arvalid, // Read address valid.
  output logic s_arready, // Read address ready.
  output logic [31:0] s_rdata, // Read data.
  output logic [1:0] s_rresp, // Read response.
  output logic s_rvalid, // Read data valid.
  input wire logic s_rready // Read data ready.
);
  import flash_erase_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SEL = 3'b001, H_SHIFT = 3'b011, H_DESEL = 3'b010,
    H_RSTLO = 3'b110, H_RSTWAIT = 3'b111
  } host_state_type;

  // --------------------
  // AXI4-Lite slave
  // --------------------
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] op_reg, rx_reg;
  logic [2:0] nbytes_reg;
  logic rd_after_reg, go_cmd, go_rst;
  logic [23:0] addr_reg;
  host_state_type st_reg;
  logic do_wr;
  assign do_wr = !s_awready && !s_wready && !s_bvalid;
  assign go_cmd = do_wr && awaddr_q == REG_CMD && wstrb_q[0] &&
                  st_reg == H_IDLE;
  assign go_rst = do_wr && awaddr_q == REG_RESET && wstrb_q[0] &&
                  wdata_q[0] && st_reg == H_IDLE;

  // Address and data are taken in either order; response follows both.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      op_reg <= '0;
      nbytes_reg <= 3'h1;
      rd_after_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      if (s_awvalid && s_awready) begin
        awaddr_q <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (do_wr) begin
        s_bvalid <= 1'b1;
        s_bresp <= (awaddr_q[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
        if (go_cmd) begin
          op_reg <= wdata_q[7:0];
          nbytes_reg <= wdata_q[10:8];
          rd_after_reg <= wdata_q[12];
        end
        if (awaddr_q == REG_ADDR) begin
          for (int i = 0; i < 3; i++) begin
            if (wstrb_q[i]) addr_reg[8*i +: 8] <= wdata_q[8*i +: 8];
          end
        end
      end
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= (s_araddr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      case (s_araddr)
        REG_CMD: s_rdata <= {19'h0, rd_after_reg, 1'b0, nbytes_reg,
                             op_reg};
        REG_ADDR: s_rdata <= {8'h00, addr_reg};
        REG_STATUS: s_rdata <= {16'h0, rx_reg, 7'h0,
                                st_reg != H_IDLE};
        default: s_rdata <= 32'h0;
      endcase
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // --------------------
  // Serial engine
  // --------------------
  logic [1:0] so_s;
  logic [15:0] div_reg;
  logic tick;
  logic [39:0] tx_reg;
  logic [5:0] bit_reg, nbits_reg;
  logic [31:0] wait_reg;
  logic sclk_reg, csn_reg, si_reg, rstn_reg;

  // Returned data is a pin input: two flops before use.
  always_ff @(posedge mclk) begin
    if (sys_rst) so_s <= 2'b11;
    else so_s <= {so_s[0], lnk.so_line};
  end

  // Half-period enable for the serial clock.
  always_ff @(posedge mclk) begin
    if (sys_rst || st_reg == H_IDLE) div_reg <= '0;
    else if (tick) div_reg <= '0;
    else div_reg <= div_reg + 16'h1;
  end
  assign tick = (div_reg == 16'(SCLK_HALF - 1));

  // Select stays low from first to last bit of each frame.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_reg <= H_IDLE;
      sclk_reg <= 1'b0;
      csn_reg <= 1'b1;
      si_reg <= 1'b0;
      rstn_reg <= 1'b1;
      tx_reg <= '0;
      bit_reg <= '0;
      nbits_reg <= '0;
      rx_reg <= '0;
      wait_reg <= '0;
    end else begin
      case (st_reg)
        H_IDLE: begin
          if (go_cmd) begin
            st_reg <= H_SEL;
            tx_reg <= {wdata_q[7:0], addr_reg, 8'h00};
            nbits_reg <= {wdata_q[10:8], 3'h0} +
                         (wdata_q[12] ? BITS_OP_ONLY : 6'h00);
            bit_reg <= '0;
          end else if (go_rst) begin
            st_reg <= H_RSTLO;
            rstn_reg <= 1'b0;
            wait_reg <= '0;
          end
        end
        H_SEL: begin
          csn_reg <= 1'b0;
          si_reg <= tx_reg[39];
          if (tick) st_reg <= H_SHIFT;
        end
        H_SHIFT: begin
          if (tick && !sclk_reg) begin
            sclk_reg <= 1'b1;
            rx_reg <= {rx_reg[6:0], so_s[1]};
            bit_reg <= bit_reg + 6'h01;
          end else if (tick) begin
            sclk_reg <= 1'b0;
            tx_reg <= {tx_reg[38:0], 1'b0};
            si_reg <= tx_reg[38];
            if (bit_reg == nbits_reg) st_reg <= H_DESEL;
          end
        end
        H_DESEL: begin
          if (tick && csn_reg) st_reg <= H_IDLE;
          else if (tick) csn_reg <= 1'b1;
        end
        H_RSTLO: begin
          wait_reg <= wait_reg + 32'h1;
          if (wait_reg == 32'(RESET_PULSE_CYC - 1)) begin
            rstn_reg <= 1'b1;
            wait_reg <= '0;
            st_reg <= H_RSTWAIT;
          end
        end
        H_RSTWAIT: begin
          wait_reg <= wait_reg + 32'h1;
          if (wait_reg == 32'(RESET_TO_SELECT_CYC - 1))
            st_reg <= H_IDLE;
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
  assign lnk.sclk = sclk_reg;
  assign lnk.cs_n = csn_reg;
  assign lnk.si = si_reg;
  assign lnk.reset_n = rstn_reg;
endmodule : flash_erase_host

/* File: shared/flash_erase_pkg.sv */
// Purpose: Shared constants for the serial flash erase link and its ends.
// Assumes: 250 MHz mclk; mode 0 serial link.
// Notes: Opcodes and register offsets are named here once.
package flash_erase_pkg;
  // --------------------
  // Instruction codes
  // --------------------
  localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_PAGE_CLEAR = 8'hdb;
  localparam logic [7:0] OP_SMALL_CLEAR = 8'h20;
  localparam logic [7:0] OP_MID_CLEAR = 8'hd8;
  localparam logic [7:0] OP_FULL_CLEAR = 8'hc7;
  // --------------------
  // Framing and layout
  // --------------------
  localparam logic [5:0] BITS_OP_ONLY = 6'h08;
  localparam logic [5:0] BITS_OP_ADDR = 6'h20;
  localparam logic [5:0] BITS_SAT = 6'h3f;
  localparam int PAGE_AW = 8;
  localparam int SMALL_AW = 12;
  localparam int MID_AW = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LATCH_BIT = 1;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // --------------------
  // Timing
  // --------------------
  localparam int CLK_NS = 4;
  localparam int RESET_TO_SELECT_WAIT_NS = 1000;
  localparam int RESET_TO_SELECT_CYC =
    (RESET_TO_SELECT_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PULSE_NS = 100;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  // --------------------
  // Controller register map (byte offsets)
  // --------------------
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_RESET = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    KIND_NONE, KIND_PAGE, KIND_SMALL, KIND_MID, KIND_FULL
  } erase_kind_type;
endpackage : flash_erase_pkg

/* File: shared/flash_link_if.sv */
// Purpose: Serial link between the erase controller and the flash device.
// Assumes: Data output is tristate; released line reads high.
// Notes: Pull-up on the data output is modelled by so_line.
`timescale 1ns/1ps
interface flash_link_if;
  logic sclk; // Serial clock from controller.
  logic cs_n; // Chip select, active low.
  logic si; // Serial data into device.
  logic reset_n; // Reset pin, active low.
  logic so; // Serial data from device.
  logic so_oe; // Device drives so while high.
  logic so_line; // Resolved data output line.

  // Released line floats up.
  assign so_line = so_oe ? so : 1'b1;

  modport dev (input sclk, input cs_n, input si, input reset_n,
               output so, output so_oe);
  modport host (output sclk, output cs_n, output si, output reset_n,
                input so_line);
endinterface : flash_link_if
